// *** src/iabe_exec.sv ***
// Purpose: Executes arithmetic, logic, product, jump, compare and skip ops.
// Assumes: Decoded instructions with a valid/ready handshake.
// Notes:   Holds the 32-entry register file, status flags and counter.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module iabe_exec
  import iabe_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            ins_valid,
  input  wire iabe_ins_t       ins,
  input  wire logic            next_long,
  output logic                 ins_ready,
  output logic [4:0]           io_addr,
  input  wire logic [7:0]      io_rdata,
  input  wire logic [5:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  output logic [PC_W-1:0]      pc,
  output logic [7:0]           flags
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_SKIP} iabe_state_t;

  iabe_state_t     st_q, st_d;
  iabe_ins_t       ins_q, ins_d;
  logic [1:0]      wait_q, wait_d;
  logic [7:0]      rf_q [32];
  logic [7:0]      rf_d [32];
  logic [7:0]      flags_q, flags_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [7:0]      rdata_q, rdata_d;

  logic            take;
  iabe_ins_t       cur;
  logic [7:0]      opd_a, opd_b, opd_k;
  logic [8:0]      sum9;
  logic [4:0]      nib5;
  logic [7:0]      res8;
  logic [15:0]     word_a, word_r;
  logic [16:0]     word_x;
  logic [17:0]     prod;
  logic [15:0]     prod16;
  logic            skip;
  logic            cin;
  logic [7:0]      sub8;
  logic            use_c;
  logic [8:0]      d9;
  logic [4:0]      h5;

  assign ins_ready = (st_q == ST_IDLE);
  assign take      = ins_valid && ins_ready;
  assign cur       = (st_q == ST_IDLE) ? ins : ins_q;
  assign io_addr   = ins.k[4:0];
  assign pc        = pc_q;
  assign flags     = flags_q;
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Operand fetch and shared arithmetic.
  always_comb begin
    opd_a  = rf_q[cur.rd];
    opd_b  = rf_q[cur.source_register];
    opd_k  = cur.k;
    cin    = flags_q[FLAG_C];
    word_a = {rf_q[cur.rd + 5'h01], rf_q[cur.rd]};
    word_x = 17'h00000;
    word_r = 16'h0000;
    prod   = 18'h00000;
    case (cur.op)
      OP_WORD_PLUS_IMMEDIATE: begin
        word_x = {1'b0, word_a} + {9'h000, opd_k}; // [RULE_02]
      end
      OP_WORD_MINUS_IMMEDIATE: begin
        word_x = {1'b0, word_a} - {9'h000, opd_k}; // [RULE_02]
      end
      OP_UNSIGNED_PRODUCT, OP_FRACTIONAL_UNSIGNED_PRODUCT: begin
        // Operands are widened first so the product keeps all 16 bits.
        prod = {2'b00, 16'(opd_a) * 16'(opd_b)}; // [RULE_07]
      end
      OP_SIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT: begin
        prod = $signed({{10{opd_a[7]}}, opd_a}) *
               $signed({{10{opd_b[7]}}, opd_b});
      end
      OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT: begin
        prod = $signed({{10{opd_a[7]}}, opd_a}) *
               $signed({10'h000, opd_b});
      end
      default: begin
        word_x = 17'h00000;
      end
    endcase
    word_r = word_x[15:0];
    prod16 = prod[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing, register file, flags and program counter.
  always_comb begin
    st_d    = st_q;
    ins_d   = ins_q;
    wait_d  = wait_q;
    rf_d    = rf_q;
    flags_d = flags_q;
    pc_d    = pc_q;
    sum9    = 9'h000;
    sub8    = 8'h00;
    use_c   = 1'b0;
    d9      = 9'h000;
    h5      = 5'h00;
    nib5    = 5'h00;
    res8    = 8'h00;
    skip    = 1'b0;

    case (st_q)
      ST_IDLE: begin
        if (take) begin
          ins_d = ins;
          pc_d  = pc_q + PC_W'(1); // [RULE_14]
          case (ins.op)
            OP_ADD, OP_ADD_CARRY: begin
              sum9 = {1'b0, opd_a} + {1'b0, opd_b}
                   + {8'h00, (ins.op == OP_ADD_CARRY) & cin}; // [RULE_01]
              nib5 = {1'b0, opd_a[3:0]} + {1'b0, opd_b[3:0]}
                   + {4'h0, (ins.op == OP_ADD_CARRY) & cin};
              res8 = sum9[7:0];
              rf_d[ins.rd] = res8; // [RULE_01]
              flags_d[FLAG_C] = sum9[8];
              flags_d[FLAG_H] = nib5[4];
              flags_d[FLAG_V] = (opd_a[7] == opd_b[7]) &&
                                (res8[7] != opd_a[7]);
              flags_d[FLAG_N] = res8[7];
              flags_d[FLAG_Z] = (res8 == 8'h00);
            end
            OP_DIFFERENCE, OP_CONSTANT_DIFFERENCE,
            OP_REGISTER_DIFFERENCE_BORROW, OP_CONSTANT_DIFFERENCE_BORROW,
            OP_REGISTER_COMPARE, OP_REGISTER_COMPARE_CARRY,
            OP_IMMEDIATE_COMPARE: begin
              if (ins.op == OP_CONSTANT_DIFFERENCE ||
                  ins.op == OP_CONSTANT_DIFFERENCE_BORROW ||
                  ins.op == OP_IMMEDIATE_COMPARE) begin
                sub8 = opd_k;
              end else begin
                sub8 = opd_b;
              end
              // Subtract and compare share one datapath.
              use_c = (ins.op == OP_REGISTER_DIFFERENCE_BORROW ||
                       ins.op == OP_CONSTANT_DIFFERENCE_BORROW ||
                       ins.op == OP_REGISTER_COMPARE_CARRY) & cin;
              d9 = {1'b0, opd_a} - {1'b0, sub8}
                 - {8'h00, use_c}; // [RULE_03] [RULE_11]
              h5 = {1'b0, opd_a[3:0]} - {1'b0, sub8[3:0]}
                 - {4'h0, use_c};
              // Only compares skip the store.
              if (ins.op != OP_REGISTER_COMPARE &&
                  ins.op != OP_REGISTER_COMPARE_CARRY &&
                  ins.op != OP_IMMEDIATE_COMPARE) begin
                rf_d[ins.rd] = d9[7:0]; // [RULE_03]
              end
              flags_d[FLAG_C] = d9[8];
              flags_d[FLAG_H] = h5[4];
              flags_d[FLAG_V] = (opd_a[7] != sub8[7]) &&
                                (d9[7] != opd_a[7]);
              flags_d[FLAG_N] = d9[7];
              flags_d[FLAG_Z] = (d9[7:0] == 8'h00); // [RULE_11]
            end
            OP_AND, OP_MASK_WITH_CONSTANT, OP_OR, OP_MERGE_WITH_CONSTANT,
            OP_EXCLUSIVE_MERGE, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS,
            OP_ZERO_MINUS_TEST: begin
              case (ins.op)
                OP_AND:                 res8 = opd_a & opd_b; // [RULE_04]
                OP_MASK_WITH_CONSTANT:  res8 = opd_a & opd_k; // [RULE_04]
                OP_OR:                  res8 = opd_a | opd_b; // [RULE_04]
                OP_MERGE_WITH_CONSTANT: res8 = opd_a | opd_k; // [RULE_04]
                OP_EXCLUSIVE_MERGE:     res8 = opd_a ^ opd_b; // [RULE_04]
                OP_SET_MASK_BITS:       res8 = opd_a | opd_k; // [RULE_05]
                OP_CLEAR_MASK_BITS:     res8 = opd_a & ~opd_k; // [RULE_05]
                default:                res8 = opd_a & opd_a; // [RULE_06]
              endcase
              rf_d[ins.rd]    = res8;
              flags_d[FLAG_V] = 1'b0;
              flags_d[FLAG_N] = res8[7];
              flags_d[FLAG_Z] = (res8 == 8'h00); // [RULE_04]
            end
            OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE,
            OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
            OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
            OP_FRACTIONAL_MIXED_PRODUCT, OP_POINTER_JUMP: begin
              // Second clock commits; for jumps it loads the counter from Z over the advance.
              st_d = ST_SECOND; // [RULE_02] [RULE_07] [RULE_09]
            end
            OP_EQUAL_COMPARE_SKIP: begin
              skip = (opd_a == opd_b); // [RULE_10]
            end
            OP_REG_BIT_CLEAR_SKIP: begin
              skip = ~opd_b[ins.bit_sel]; // [RULE_12]
            end
            OP_REG_BIT_SET_SKIP: begin
              skip = opd_b[ins.bit_sel]; // [RULE_12]
            end
            OP_IO_BIT_CLEAR_SKIP: begin
              skip = ~io_rdata[ins.bit_sel]; // [RULE_13]
            end
            default: begin
              res8 = 8'h00;
            end
          endcase
          if (skip) begin
            // The skipped word or words are not fetched again.
            pc_d   = pc_q + PC_W'(next_long ? SKIP_LONG : SKIP_SHORT); // [RULE_10]
            wait_d = next_long ? 2'h2 : 2'h1; // [RULE_12] [RULE_13]
            st_d   = ST_SKIP;
          end
        end
      end
      ST_SECOND: begin
        st_d = ST_IDLE;
        case (ins_q.op)
          OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
            rf_d[ins_q.rd]          = word_r[7:0]; // [RULE_02]
            rf_d[ins_q.rd + 5'h01]  = word_r[15:8];
            flags_d[FLAG_C] = word_x[16];
            flags_d[FLAG_N] = word_r[15];
            flags_d[FLAG_Z] = (word_r == 16'h0000);
            if (ins_q.op == OP_WORD_PLUS_IMMEDIATE) begin
              flags_d[FLAG_V] = ~word_a[15] & word_r[15];
            end else begin
              flags_d[FLAG_V] = word_a[15] & ~word_r[15];
            end
            flags_d[FLAG_S] = word_r[15] ^ flags_d[FLAG_V]; // [RULE_02]
          end
          OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT,
          OP_MIXED_SIGN_PRODUCT: begin
            rf_d[REG_PROD_LO] = prod16[7:0]; // [RULE_07]
            rf_d[REG_PROD_HI] = prod16[15:8];
            flags_d[FLAG_C]   = prod16[15];
            flags_d[FLAG_Z]   = (prod16 == 16'h0000); // [RULE_07]
          end
          OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
          OP_FRACTIONAL_MIXED_PRODUCT: begin
            rf_d[REG_PROD_LO] = {prod16[6:0], 1'b0}; // [RULE_08]
            rf_d[REG_PROD_HI] = prod16[14:7];
            flags_d[FLAG_C]   = prod16[15];
            flags_d[FLAG_Z]   = (prod16[14:0] == 15'h0000); // [RULE_08]
          end
          OP_POINTER_JUMP: begin
            pc_d = PC_W'({rf_q[REG_Z_HI], rf_q[REG_Z_LO]}); // [RULE_09]
          end
          default: begin
            st_d = ST_IDLE;
          end
        endcase
      end
      ST_SKIP: begin
        wait_d = wait_q - 2'h1;
        if (wait_q == 2'h1) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase

    // Software writes land after execution, so they win a same-cycle clash.
    if (reg_wr) begin
      if (reg_addr <= MAP_GPR_LAST) begin
        rf_d[reg_addr[4:0]] = reg_wdata;
      end else if (reg_addr == MAP_FLAGS) begin
        flags_d = reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software read port. Data stand only in the cycle after the strobe, so
  // a reader that is late sees zero rather than stale contents.
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      if (reg_addr <= MAP_GPR_LAST) begin
        rdata_d = rf_q[reg_addr[4:0]];
      end else if (reg_addr == MAP_FLAGS) begin
        rdata_d = flags_q;
      end else if (reg_addr == MAP_PC_LO) begin
        rdata_d = 8'(pc_q);
      end else if (reg_addr == MAP_PC_HI) begin
        rdata_d = 8'(pc_q >> 8);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q    <= ST_IDLE;
      ins_q   <= '0;
      wait_q  <= 2'h0;
      flags_q <= RST_FLAGS;
      pc_q    <= PC_W'(RST_PC);
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= RST_GPR;
      end
    end else begin
      st_q    <= st_d;
      ins_q   <= ins_d;
      wait_q  <= wait_d;
      flags_q <= flags_d; // [RULE_14]
      pc_q    <= pc_d;
      rf_q    <= rf_d;
    end
  end

endmodule : iabe_exec

// *** pkg/iabe_pkg.sv ***
// Purpose: Shared constants and types for the 8-bit execution unit.
// Assumes: One core clock, asynchronous active-high reset.
// Notes:   Instructions arrive already decoded as an iabe_ins_t word.
//
// How it works
// [RULE_01] Register sums write Rd, flags ZCNVH, one clock.
// [RULE_02] Word plus/minus immediate on pair, two clocks.
// [RULE_03] Differences with optional borrow write Rd, ZCNVH.
// [RULE_04] AND, OR, exclusive merge set only Z N V.
// [RULE_05] Set mask ORs, clear mask ANDs inverted constant.
// [RULE_06] Zero minus test keeps Rd, sets Z N V.
// [RULE_07] Three products write R1:R0, flags Z C, two clocks.
// [RULE_08] Fractional products shift left one, two clocks.
// [RULE_09] Pointer jump loads counter from Z, two clocks.
// [RULE_10] Equal compare skip advances by two or three.
// [RULE_11] Compares subtract without storing, set ZNVCH.
// [RULE_12] Register bit skips test bit of source register.
// [RULE_13] I/O bit skip skips when tested bit zero.
// [RULE_14] Others advance by one; untouched flags stay.
package iabe_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_WORD_PLUS_IMMEDIATE,
    OP_DIFFERENCE, OP_CONSTANT_DIFFERENCE, OP_REGISTER_DIFFERENCE_BORROW,
    OP_CONSTANT_DIFFERENCE_BORROW, OP_WORD_MINUS_IMMEDIATE,
    OP_AND, OP_MASK_WITH_CONSTANT, OP_OR, OP_MERGE_WITH_CONSTANT,
    OP_EXCLUSIVE_MERGE, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS,
    OP_ZERO_MINUS_TEST, OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT,
    OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_UNSIGNED_PRODUCT,
    OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT,
    OP_POINTER_JUMP, OP_EQUAL_COMPARE_SKIP, OP_REGISTER_COMPARE,
    OP_REGISTER_COMPARE_CARRY, OP_IMMEDIATE_COMPARE,
    OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLEAR_SKIP
  } iabe_op_t;

  typedef struct packed {
    iabe_op_t    op;
    logic [4:0]  rd;
    logic [4:0]  source_register;
    logic [7:0]  k;
    logic [2:0]  bit_sel;
  } iabe_ins_t;

  // Status flag positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // Register port map, in register indices.
  localparam logic [5:0] MAP_GPR_LAST = 6'h1f;
  localparam logic [5:0] MAP_FLAGS    = 6'h20;
  localparam logic [5:0] MAP_PC_LO    = 6'h21;
  localparam logic [5:0] MAP_PC_HI    = 6'h22;

  // Fixed register numbers.
  localparam logic [4:0] REG_PROD_LO = 5'h00;
  localparam logic [4:0] REG_PROD_HI = 5'h01;
  localparam logic [4:0] REG_Z_LO    = 5'h1e;
  localparam logic [4:0] REG_Z_HI    = 5'h1f;

  // Reset values and counts.
  localparam logic [7:0]  RST_FLAGS     = 8'h00;
  localparam logic [7:0]  RST_GPR       = 8'h00;
  localparam logic [15:0] RST_PC        = 16'h0000;
  localparam logic [1:0]  SKIP_SHORT    = 2'h2;
  localparam logic [1:0]  SKIP_LONG     = 2'h3;

endpackage : iabe_pkg

// *** testbench/iabe_exec_props.sv ***
// Purpose: Port-level timing and flag checks for the execution unit.
// Assumes: One core clock, asynchronous active-high reset.
// Notes:   Attached to iabe_exec by the bind after the module.
`timescale 1ns/10ps
module iabe_exec_props
  import iabe_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic            core_clk,
  input wire logic            rst,
  input wire logic            ins_valid,
  input wire iabe_ins_t       ins,
  input wire logic            next_long,
  input wire logic            ins_ready,
  input wire logic [7:0]      io_rdata,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0]      flags
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take(iabe_op_t o);
    ins_valid && ins_ready && ins.op == o;
  endsequence
  // A two-clock op refuses exactly one following cycle, then frees up.
  sequence s_stall1;
    !ins_ready ##1 ins_ready;
  endsequence
  property p_sum;
    s_take(OP_ADD) |=> pc == $past(pc) + 1'b1 && ins_ready;
  endproperty
  a_sum: assert property (p_sum) else $error("sum pc step wrong");
  property p_word;
    s_take(OP_WORD_PLUS_IMMEDIATE) |=> s_stall1;
  endproperty
  a_word: assert property (p_word) else $error("word op length");
  property p_prod;
    s_take(OP_UNSIGNED_PRODUCT) |=> pc == $past(pc) + 1'b1 ##0 s_stall1;
  endproperty
  a_prod: assert property (p_prod) else $error("product length");
  property p_frac;
    s_take(OP_FRACTIONAL_SIGNED_PRODUCT) |=> s_stall1;
  endproperty
  a_frac: assert property (p_frac) else $error("fraction length");
  property p_jump;
    s_take(OP_POINTER_JUMP) |=> ##1 flags == $past(flags, 2);
  endproperty
  a_jump: assert property (p_jump) else $error("jump moved flags");
  property p_eqskip;
    s_take(OP_EQUAL_COMPARE_SKIP) |=> flags == $past(flags);
  endproperty
  a_eqskip: assert property (p_eqskip) else $error("skip flags");
  property p_mask;
    s_take(OP_CLEAR_MASK_BITS) |=> !flags[FLAG_V] && ins_ready;
  endproperty
  a_mask: assert property (p_mask) else $error("mask V not clear");
  property p_cmp;
    s_take(OP_REGISTER_COMPARE) |=> pc == $past(pc) + 1'b1 ##0 ins_ready;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare pc step");
  property p_ioskip;
    s_take(OP_IO_BIT_CLEAR_SKIP) ##0 (!io_rdata[ins.bit_sel] && next_long)
      |=> pc == $past(pc) + 2'h3 ##0 !ins_ready [*2] ##1 ins_ready;
  endproperty
  a_ioskip: assert property (p_ioskip) else $error("io skip long");
endmodule : iabe_exec_props

bind iabe_exec iabe_exec_props #(.PC_W(PC_W)) i_iabe_exec_props (
  .core_clk(core_clk), .rst(rst), .ins_valid(ins_valid), .ins(ins),
  .next_long(next_long), .ins_ready(ins_ready), .io_rdata(io_rdata),
  .pc(pc), .flags(flags));

// *** testbench/iabe_io_model.sv ***
// Purpose: I/O register space seen by the bit-skip test.
// Assumes: Read is combinational from the address, same clock domain.
// Notes:   Contents are a fixed function of the address.
`timescale 1ns/10ps
module iabe_io_model (
  input  wire logic [4:0] io_addr,
  output logic      [7:0] io_rdata
);
  // A fixed pattern lets the bench predict every tested bit without state.
  assign io_rdata = {io_addr[2:0], io_addr};
endmodule : iabe_io_model

// *** testbench/iabe_exec_tb_top.sv ***
// Purpose: Self-checking bench for the execution unit.
// Assumes: Registers preset over the software port.
// Notes:   Each op is followed by three idle edges, enough for any stall.
`timescale 1ns/10ps
module iabe_exec_tb_top;
  import iabe_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        ins_valid;
  iabe_ins_t   ins;
  logic        next_long;
  logic        ins_ready;
  logic [4:0]  io_addr;
  logic [7:0]  io_rdata;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [15:0] pc;
  logic [7:0]  flags;
  logic [15:0] exp_pc;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  iabe_exec #(.PC_W(16)) i_iabe_exec (.core_clk(core_clk), .rst(rst),
    .ins_valid(ins_valid), .ins(ins), .next_long(next_long),
    .ins_ready(ins_ready), .io_addr(io_addr), .io_rdata(io_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc(pc), .flags(flags));
  iabe_io_model i_iabe_io_model (.io_addr(io_addr), .io_rdata(io_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge core_clk);
  endtask : rd_chk
  task automatic run(input iabe_op_t op, input logic [4:0] d, s,
    input logic [7:0] k, input logic [2:0] b, input logic lng,
    input logic [15:0] epc);
    ins_valid <= 1'b1;
    ins <= {op, d, s, k, b};
    next_long <= lng;
    @(posedge core_clk);
    ins_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    exp_pc = epc;
    #1 check(pc, exp_pc);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_alu();
    rd_chk(MAP_FLAGS, RST_FLAGS);
    rd_chk(6'h3f, 8'h00);
    wr(6'h10, 8'h0f);
    wr(6'h11, 8'h01);
    run(OP_ADD, 5'h10, 5'h11, 8'h00, 3'h0, 1'b0, exp_pc + 16'h1);
    rd_chk(6'h10, 8'h10);
    rd_chk(MAP_FLAGS, 8'h20);
    wr(6'h11, 8'h11);
    run(OP_DIFFERENCE, 5'h10, 5'h11, 8'h00, 3'h0, 1'b0, exp_pc + 16'h1);
    rd_chk(6'h10, 8'hff);
    rd_chk(MAP_FLAGS, 8'h25);
    run(OP_REGISTER_COMPARE, 5'h10, 5'h11, 8'h00, 3'h0, 1'b0, exp_pc + 16'h1);
    rd_chk(6'h10, 8'hff);
    rd_chk(MAP_FLAGS, 8'h04);
    run(OP_CLEAR_MASK_BITS, 5'h10, 5'h00, 8'h0f, 3'h0, 1'b0, exp_pc + 16'h1);
    rd_chk(6'h10, 8'hf0);
    run(OP_SET_MASK_BITS, 5'h10, 5'h00, 8'h03, 3'h0, 1'b0, exp_pc + 16'h1);
    rd_chk(6'h10, 8'hf3);
    run(OP_ZERO_MINUS_TEST, 5'h12, 5'h00, 8'h00, 3'h0, 1'b0, exp_pc + 16'h1);
    rd_chk(MAP_FLAGS, 8'h02);
    run(OP_OR, 5'h12, 5'h10, 8'h00, 3'h0, 1'b0, exp_pc + 16'h1);
    rd_chk(6'h12, 8'hf3);
    rd_chk(MAP_FLAGS, 8'h04);
  endtask : t_alu
  task automatic t_prod();
    iabe_op_t   pops [6];
    logic [7:0] phi [6];
    pops = '{OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
      OP_FRACTIONAL_MIXED_PRODUCT};
    phi = '{8'h01, 8'hff, 8'hff, 8'h02, 8'hfe, 8'hfe};
    wr(6'h02, 8'h80);
    wr(6'h03, 8'h02);
    for (int i = 0; i < 6; i++) begin
      run(pops[i], 5'h02, 5'h03, 8'h00, 3'h0, 1'b0, exp_pc + 16'h1);
      rd_chk(REG_PROD_HI, phi[i]);
      rd_chk(REG_PROD_LO, 8'h00);
    end
  endtask : t_prod
  task automatic t_word_jump();
    wr(6'h18, 8'hff);
    wr(6'h19, 8'h00);
    run(OP_WORD_PLUS_IMMEDIATE, 5'h18, 5'h00, 8'h01, 3'h0, 1'b0,
      exp_pc + 16'h1);
    rd_chk(6'h19, 8'h01);
    rd_chk(6'h18, 8'h00);
    rd_chk(MAP_FLAGS, 8'h00);
    run(OP_WORD_MINUS_IMMEDIATE, 5'h18, 5'h00, 8'h02, 3'h0, 1'b0,
      exp_pc + 16'h1);
    rd_chk(6'h19, 8'h00);
    rd_chk(6'h18, 8'hfe);
    wr({1'b0, REG_Z_LO}, 8'h34);
    wr({1'b0, REG_Z_HI}, 8'h12);
    run(OP_POINTER_JUMP, 5'h00, 5'h00, 8'h00, 3'h0, 1'b0, 16'h1234);
  endtask : t_word_jump
  task automatic t_skip();
    run(OP_IO_BIT_CLEAR_SKIP, 5'h00, 5'h00, 8'h10, 3'h0, 1'b1,
      exp_pc + 16'h3);
    run(OP_IO_BIT_CLEAR_SKIP, 5'h00, 5'h00, 8'h10, 3'h4, 1'b1,
      exp_pc + 16'h1);
    run(OP_EQUAL_COMPARE_SKIP, 5'h10, 5'h10, 8'h00, 3'h0, 1'b0,
      exp_pc + 16'h2);
    run(OP_REG_BIT_SET_SKIP, 5'h00, 5'h10, 8'h00, 3'h7, 1'b1,
      exp_pc + 16'h3);
    run(OP_REG_BIT_CLEAR_SKIP, 5'h00, 5'h10, 8'h00, 3'h2, 1'b0,
      exp_pc + 16'h2);
  endtask : t_skip
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    ins_valid = 1'b0;
    ins = '0;
    next_long = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    exp_pc = RST_PC;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_alu();
    t_prod();
    t_word_jump();
    t_skip();
    complete_run();
  end
endmodule : iabe_exec_tb_top
